/* File: pkg/hbiu_if.sv */
// pins between the host and the device; resolves shared wires
// assumes every driver is qualified by its own enable
`timescale 1ns/1ps
interface hbiu_if;
  logic        host_bus_clock;
  logic [15:1] addr;
  logic        address_qualifier_n;
  logic [1:0]  byte_lane_select_n;
  logic        address_latch_strobe_n;
  logic [15:0] host_d_o;
  logic        host_d_oe;
  logic [15:0] dev_ad_o;
  logic        dev_ad_oe;
  logic [15:0] dev_sd_o;
  logic        dev_sd_oe;
  logic [15:0] data;
  logic        sync_cycle_frame_n;
  logic        transfer_direction;
  logic        local_bus_select_n;
  logic        async_read_strobe_n;
  logic        async_write_strobe_n;
  logic        async_ready_oe;
  logic        async_ready_od;
  logic        sync_ready_out_n;
  logic        ready_return_in_n;
  logic        host_interrupt;
  logic        local_device_hit_n;
  logic        host_reset;
  // weak pullups on data and the open-drain ready
  assign data = dev_ad_oe ? dev_ad_o : dev_sd_oe ? dev_sd_o :
                host_d_oe ? host_d_o : hbiu_pkg::BUS_IDLE;
  assign async_ready_od = ~async_ready_oe;
  modport device (
    input  host_bus_clock, addr, address_qualifier_n,
    input  byte_lane_select_n, address_latch_strobe_n, data,
    input  sync_cycle_frame_n, transfer_direction, local_bus_select_n,
    input  async_read_strobe_n, async_write_strobe_n,
    input  ready_return_in_n, host_reset,
    output dev_ad_o, dev_ad_oe, dev_sd_o, dev_sd_oe, async_ready_oe,
    output sync_ready_out_n, host_interrupt, local_device_hit_n
  );
  modport host (
    output host_bus_clock, addr, address_qualifier_n,
    output byte_lane_select_n, address_latch_strobe_n, host_d_o,
    output host_d_oe, sync_cycle_frame_n, transfer_direction,
    output local_bus_select_n, async_read_strobe_n,
    output async_write_strobe_n, ready_return_in_n, host_reset,
    input  data, async_ready_od, sync_ready_out_n, host_interrupt,
    input  local_device_hit_n
  );
endinterface

/* File: pkg/hbiu_pkg.sv */
// constants shared by both ends of the host bus interface
// assumes a 25 MHz reference clock at each end
package hbiu_pkg;
  localparam int unsigned SYS_CLK_NS  = 40;
  localparam int unsigned RST_MIN_NS  = 100;
  localparam int unsigned RST_FILT_CYC =
    (RST_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned EE_SK_NS    = 4000;
  localparam int unsigned EE_HALF_CYC = EE_SK_NS / (2 * SYS_CLK_NS);
  localparam int unsigned LINK_DIV    = 4;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned REG_AW      = 3;
  localparam int unsigned NUM_REGS    = 8;
  localparam int unsigned DEC_LSB     = 3;
  localparam logic [2:0] BASE_IDX     = 3'h1;
  localparam logic [2:0] EE_IDX       = 3'h2;
  localparam logic [2:0] IRQ_STAT_IDX = 3'h6;
  localparam logic [2:0] IRQ_MASK_IDX = 3'h7;
  localparam logic [15:0] BASE_RST    = 16'h0300;
  localparam logic [15:0] REG_RST     = 16'h0000;
  localparam logic [15:0] IRQ_EE_BIT  = 16'h0001;
  localparam logic [15:0] BUS_IDLE    = 16'hffff;
  localparam int unsigned ASYNC_HOLD_CYC = 4;
  localparam int unsigned HOST_STROBE_CYC = 8;
  localparam int unsigned EE_CMD_W    = 9;
  localparam int unsigned EE_BITS     = EE_CMD_W + DATA_W;
  localparam logic [8:0] EE_READ_CMD  = 9'h180;
endpackage

/* File: src/hbiu_device.sv */
// device end of the host bus interface: decode, register file,
// async strobes, sync cycles, reset filter, eeprom loader
// assumes sys_clk_i is the 25 MHz reference; link logic runs on
// the host bus clock
// Function
// R1: decode only while qualifier low
// R2: hit output when upper address matches base
// R3: hit combinational from live pins
// R4: A1-A3 pick the register
// R5: byte lanes set width and bytes
// R6: 16-bit bidirectional data bus
// R7: reset pin restores defaults, reloads eeprom
// R8: reset pin needs 100 ns high
// R9: address latched at strobe rising edge
// R10: host frames write one clock early
// R11: host frames read two clocks early
// R12: direction high write, low read
// R13: select low gives local bus mode
// R14: host bus clock at most 50 MHz
// R15: async ready released on reference clock
// R16: sync ready falls to complete
// R17: ready return ends sync reads
// R18: interrupt output active high
// R19: async reads, writes use strobes
// R20: eeprom clock period 4 us
// R21: eeprom select frames each command
// R22: eeprom used only when enabled
// R23: eeprom data out and in pins
// R24: drive data only on decoded reads
`timescale 1ns/1ps
module hbiu_device (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  hbiu_if.device    bus,
  input  wire logic eeprom_serial_in_i,
  input  wire logic eeprom_access_enable_i,
  output logic      eeprom_serial_clock_o,
  output logic      eeprom_select_o,
  output logic      eeprom_serial_out_o
);
  localparam int unsigned PW = 40;

  typedef enum logic [1:0] {A_IDLE, A_BUSY, A_HOLD} hbiu_a_st_t;
  typedef enum logic [1:0] {S_IDLE, S_WDATA, S_WAIT, S_DONE} hbiu_s_st_t;
  typedef enum logic [1:0] {E_IDLE, E_SHIFT} hbiu_e_st_t;

  function automatic logic is_hit(input logic aen_n,
                                  input logic [15:1] a,
                                  input logic [15:0] base);
    is_hit = ~aen_n & (a[15:4] == base[15:4]); // R1 R2
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] wd,
                                             input logic [1:0] be_n);
    lane_merge = {be_n[1] ? old_v[15:8] : wd[15:8],
                  be_n[0] ? old_v[7:0] : wd[7:0]}; // R5
  endfunction

  logic [15:0] regs_ff [hbiu_pkg::NUM_REGS];
  logic [PW-1:0] pin_s1_ff;
  logic [PW-1:0] pin_s2_ff;
  logic [15:1] lat_addr_ff;
  logic        lat_aen_ff;
  logic [2:0]  rst_cnt_ff;
  logic        soft_rst_ff;
  logic        ee_pend_ff;
  hbiu_a_st_t  a_st_ff;
  logic [2:0]  a_cnt_ff;
  logic [15:0] srdata_ff;
  logic        req_s1_ff, req_s2_ff, req_s3_ff, ack_tgl_ff;
  hbiu_e_st_t  e_st_ff;
  logic [6:0]  e_div_ff;
  logic [4:0]  e_bit_ff;
  logic [15:0] e_shift_ff;
  logic        ee_done;
  // link domain
  hbiu_s_st_t  s_st_ff;
  logic [15:1] lk_addr_ff;
  logic        lk_aen_ff;
  logic [2:0]  lk_idx_ff;
  logic [1:0]  lk_be_ff;
  logic        lk_we_ff;
  logic [15:0] lk_wd_ff;
  logic        req_tgl_ff, ack_s1_ff, ack_s2_ff, ack_s3_ff;

  // live-pin decode, no latch in the path
  assign bus.local_device_hit_n =
    ~is_hit(bus.address_qualifier_n, bus.addr, regs_ff[hbiu_pkg::BASE_IDX]); // R3

  // two-flop synchronisers for pins into the reference domain
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_ff <= '1;
      pin_s2_ff <= '1;
    end else begin
      pin_s1_ff <= {bus.host_reset, eeprom_access_enable_i,
                    eeprom_serial_in_i, bus.address_latch_strobe_n,
                    bus.async_read_strobe_n, bus.async_write_strobe_n,
                    bus.address_qualifier_n, bus.byte_lane_select_n,
                    bus.addr, bus.data};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  logic        rst_s, een_s, edi_s, ads_s, rd_s, wr_s, aen_s;
  logic [1:0]  be_s;
  logic [15:1] addr_s;
  logic [15:0] d_s;
  assign {rst_s, een_s, edi_s, ads_s, rd_s, wr_s, aen_s, be_s, addr_s,
          d_s} = pin_s2_ff;

  // transparent while strobe low, held from its rising edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_addr_ff <= '0;
      lat_aen_ff  <= 1'b1;
    end else if (!ads_s) begin
      lat_addr_ff <= addr_s; // R9
      lat_aen_ff  <= aen_s;
    end
  end

  logic [15:1] a_addr;
  logic        a_aen;
  assign a_addr = ads_s ? lat_addr_ff : addr_s;
  assign a_aen  = ads_s ? lat_aen_ff : aen_s;

  // reset pin glitch filter
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt_ff  <= '0;
      soft_rst_ff <= 1'b0;
    end else if (!rst_s) begin
      rst_cnt_ff  <= '0;
      soft_rst_ff <= 1'b0;
    end else if (rst_cnt_ff == 3'(hbiu_pkg::RST_FILT_CYC - 1)) begin
      soft_rst_ff <= 1'b1; // R8
    end else begin
      rst_cnt_ff <= rst_cnt_ff + 3'h1;
    end
  end

  // sync request handshake into the reference domain
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  logic sreq_evt, a_go, a_rd;
  assign sreq_evt = req_s2_ff ^ req_s3_ff;
  assign a_rd = ~rd_s;
  assign a_go = (a_st_ff == A_IDLE) & ~sreq_evt & (~rd_s | ~wr_s) &
                is_hit(a_aen, a_addr, regs_ff[hbiu_pkg::BASE_IDX]); // R19

  // single write port of the register file
  logic        w_en;
  logic [2:0]  w_idx;
  logic [15:0] w_dat;
  logic [1:0]  w_be;
  always_comb begin
    w_en  = 1'b0;
    w_idx = a_addr[3:1]; // R4
    w_dat = d_s;
    w_be  = be_s;
    if (sreq_evt) begin
      w_en  = lk_we_ff;
      w_idx = lk_idx_ff;
      w_dat = lk_wd_ff;
      w_be  = lk_be_ff;
    end else if (a_go) begin
      w_en = ~a_rd;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < hbiu_pkg::NUM_REGS; i++) regs_ff[i] <= hbiu_pkg::REG_RST;
      regs_ff[hbiu_pkg::BASE_IDX] <= hbiu_pkg::BASE_RST;
    end else if (soft_rst_ff) begin
      for (int i = 0; i < hbiu_pkg::NUM_REGS; i++) regs_ff[i] <= hbiu_pkg::REG_RST; // R7
      regs_ff[hbiu_pkg::BASE_IDX] <= hbiu_pkg::BASE_RST;
    end else begin
      if (w_en && w_idx != hbiu_pkg::IRQ_STAT_IDX)
        regs_ff[w_idx] <= lane_merge(regs_ff[w_idx], w_dat, w_be);
      if (ee_done)
        regs_ff[hbiu_pkg::EE_IDX] <= e_shift_ff;
      // write one clears, a new event wins
      regs_ff[hbiu_pkg::IRQ_STAT_IDX] <=
        (regs_ff[hbiu_pkg::IRQ_STAT_IDX] &
         ~((w_en && w_idx == hbiu_pkg::IRQ_STAT_IDX) ?
           lane_merge('0, w_dat, w_be) : '0)) |
        (ee_done ? hbiu_pkg::IRQ_EE_BIT : '0);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) bus.host_interrupt <= 1'b0;
    else bus.host_interrupt <= |(regs_ff[hbiu_pkg::IRQ_STAT_IDX] &
                                 regs_ff[hbiu_pkg::IRQ_MASK_IDX]); // R18
  end

  // async access: ready pulled low, released on reference clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_st_ff            <= A_IDLE;
      a_cnt_ff           <= '0;
      bus.async_ready_oe <= 1'b0;
      bus.dev_ad_oe      <= 1'b0;
      bus.dev_ad_o       <= '0;
    end else begin
      unique case (a_st_ff)
        A_IDLE: begin
          if (a_go) begin
            bus.async_ready_oe <= 1'b1;
            bus.dev_ad_o       <= regs_ff[a_addr[3:1]];
            bus.dev_ad_oe      <= a_rd; // R24 R6
            a_cnt_ff           <= '0;
            a_st_ff            <= A_BUSY;
          end
        end
        A_BUSY: begin
          a_cnt_ff <= a_cnt_ff + 3'h1;
          if (a_cnt_ff == 3'(hbiu_pkg::ASYNC_HOLD_CYC - 1)) begin
            bus.async_ready_oe <= 1'b0; // R15
            a_st_ff            <= A_HOLD;
          end
        end
        A_HOLD: begin
          if (rd_s && wr_s) begin
            bus.dev_ad_oe <= 1'b0;
            a_st_ff       <= A_IDLE;
          end
        end
        default: a_st_ff <= A_IDLE;
      endcase
    end
  end

  // sync read data captured and acknowledged by toggle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      srdata_ff  <= '0;
      ack_tgl_ff <= 1'b0;
    end else if (sreq_evt) begin
      srdata_ff  <= regs_ff[lk_idx_ff];
      ack_tgl_ff <= ~ack_tgl_ff;
    end
  end

  // eeprom loader, one read word after any reset
  assign ee_done = (e_st_ff == E_SHIFT) & eeprom_serial_clock_o &
                   (e_div_ff == 7'(hbiu_pkg::EE_HALF_CYC - 1)) &
                   (e_bit_ff == 5'(hbiu_pkg::EE_BITS - 1));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e_st_ff               <= E_IDLE;
      ee_pend_ff            <= 1'b1;
      e_div_ff              <= '0;
      e_bit_ff              <= '0;
      e_shift_ff            <= '0;
      eeprom_select_o       <= 1'b0;
      eeprom_serial_clock_o <= 1'b0;
      eeprom_serial_out_o   <= 1'b0;
    end else if (soft_rst_ff) begin
      e_st_ff               <= E_IDLE;
      ee_pend_ff            <= 1'b1; // R7
      eeprom_select_o       <= 1'b0;
      eeprom_serial_clock_o <= 1'b0;
    end else begin
      unique case (e_st_ff)
        E_IDLE: begin
          if (ee_pend_ff) begin
            ee_pend_ff <= 1'b0;
            if (een_s) begin // R22
              eeprom_select_o     <= 1'b1; // R21
              eeprom_serial_out_o <= hbiu_pkg::EE_READ_CMD[8]; // R23
              e_div_ff            <= '0;
              e_bit_ff            <= '0;
              e_st_ff             <= E_SHIFT;
            end
          end
        end
        E_SHIFT: begin
          e_div_ff <= e_div_ff + 7'h1;
          if (e_div_ff == 7'(hbiu_pkg::EE_HALF_CYC - 1)) begin // R20
            e_div_ff              <= '0;
            eeprom_serial_clock_o <= ~eeprom_serial_clock_o;
            if (!eeprom_serial_clock_o) begin
              if (e_bit_ff >= 5'(hbiu_pkg::EE_CMD_W))
                e_shift_ff <= {e_shift_ff[14:0], edi_s}; // R23
            end else if (ee_done) begin
              eeprom_select_o     <= 1'b0; // R21
              eeprom_serial_out_o <= 1'b0;
              e_st_ff             <= E_IDLE;
            end else begin
              e_bit_ff <= e_bit_ff + 5'h1;
              eeprom_serial_out_o <= (e_bit_ff < 5'(hbiu_pkg::EE_CMD_W - 1)) &
                hbiu_pkg::EE_READ_CMD[4'(hbiu_pkg::EE_CMD_W - 2) - 4'(e_bit_ff)];
            end
          end
        end
        default: e_st_ff <= E_IDLE;
      endcase
    end
  end

  // link domain: synchronous cycles on the host bus clock
  always_ff @(posedge bus.host_bus_clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
      lk_addr_ff <= '0;
      lk_aen_ff  <= 1'b1;
    end else begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      if (!bus.address_latch_strobe_n) begin
        lk_addr_ff <= bus.addr; // R9
        lk_aen_ff  <= bus.address_qualifier_n;
      end
    end
  end

  logic [15:1] s_addr;
  logic        s_aen;
  assign s_addr = bus.address_latch_strobe_n ? lk_addr_ff : bus.addr;
  assign s_aen  = bus.address_latch_strobe_n ? lk_aen_ff :
                  bus.address_qualifier_n;

  always_ff @(posedge bus.host_bus_clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_st_ff              <= S_IDLE;
      lk_idx_ff            <= '0;
      lk_be_ff             <= '1;
      lk_we_ff             <= 1'b0;
      lk_wd_ff             <= '0;
      req_tgl_ff           <= 1'b0;
      bus.sync_ready_out_n <= 1'b1;
      bus.dev_sd_oe        <= 1'b0;
      bus.dev_sd_o         <= '0;
    end else begin
      unique case (s_st_ff)
        S_IDLE: begin
          if (!bus.sync_cycle_frame_n &&
              is_hit(s_aen, s_addr, regs_ff[hbiu_pkg::BASE_IDX])) begin
            lk_idx_ff <= s_addr[3:1]; // R4
            lk_be_ff  <= bus.byte_lane_select_n;
            lk_we_ff  <= bus.transfer_direction; // R12
            if (bus.transfer_direction) begin
              s_st_ff <= S_WDATA;
            end else begin
              req_tgl_ff <= ~req_tgl_ff; // R11
              s_st_ff    <= S_WAIT;
            end
          end
        end
        S_WDATA: begin
          lk_wd_ff   <= bus.data; // R10
          req_tgl_ff <= ~req_tgl_ff;
          s_st_ff    <= S_WAIT;
        end
        S_WAIT: begin
          if (ack_s2_ff ^ ack_s3_ff) begin
            bus.dev_sd_o         <= srdata_ff;
            bus.dev_sd_oe        <= ~lk_we_ff; // R24
            bus.sync_ready_out_n <= bus.local_bus_select_n; // R13 R16
            s_st_ff              <= S_DONE;
          end
        end
        S_DONE: begin
          bus.sync_ready_out_n <= 1'b1;
          if (lk_we_ff || !bus.ready_return_in_n) begin // R17
            bus.dev_sd_oe <= 1'b0;
            s_st_ff       <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* File: src/hbiu_host.sv */
// host end: runs one async or sync register access per request
// assumes sys_clk_i is 25 MHz; it divides it into the bus clock
`timescale 1ns/1ps
module hbiu_host (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  hbiu_if.host             bus,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        sync_i,
  input  wire logic [15:1] addr_i,
  input  wire logic [1:0]  be_n_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        reset_req_i,
  output logic [15:0]      rdata_o,
  output logic             done_o,
  output logic             busy_o,
  output logic             irq_o
);
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_STROBE, H_CYC, H_WAIT,
                            H_RTN} hbiu_h_st_t;

  hbiu_h_st_t h_st_ff;
  logic [1:0] div_ff;
  logic [3:0] cnt_ff;
  logic       we_ff;
  logic       rdy_s1_ff, rdy_s2_ff, irq_s1_ff;
  logic       fall_evt;

  // bus clock held high unless sync mode is selected
  assign fall_evt = sync_i & (div_ff == 2'(hbiu_pkg::LINK_DIV / 2 - 1));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff             <= '0;
      bus.host_bus_clock <= 1'b1;
    end else begin
      div_ff             <= sync_i ? div_ff + 2'h1 : '0;
      bus.host_bus_clock <= ~fall_evt & (bus.host_bus_clock | ~sync_i | // R14
                            (div_ff == 2'(hbiu_pkg::LINK_DIV - 1)));
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_s1_ff      <= 1'b1;
      rdy_s2_ff      <= 1'b1;
      irq_s1_ff      <= 1'b0;
      irq_o          <= 1'b0;
      bus.host_reset <= 1'b0;
    end else begin
      rdy_s1_ff      <= bus.async_ready_od;
      rdy_s2_ff      <= rdy_s1_ff;
      irq_s1_ff      <= bus.host_interrupt;
      irq_o          <= irq_s1_ff;
      bus.host_reset <= reset_req_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      h_st_ff                    <= H_IDLE;
      cnt_ff                     <= '0;
      we_ff                      <= 1'b0;
      rdata_o                    <= '0;
      done_o                     <= 1'b0;
      busy_o                     <= 1'b0;
      bus.addr                   <= '0;
      bus.address_qualifier_n    <= 1'b1;
      bus.byte_lane_select_n     <= '1;
      bus.address_latch_strobe_n <= 1'b1;
      bus.host_d_o               <= '0;
      bus.host_d_oe              <= 1'b0;
      bus.sync_cycle_frame_n     <= 1'b1;
      bus.transfer_direction     <= 1'b0;
      bus.local_bus_select_n     <= 1'b0;
      bus.async_read_strobe_n    <= 1'b1;
      bus.async_write_strobe_n   <= 1'b1;
      bus.ready_return_in_n      <= 1'b1;
    end else begin
      done_o <= 1'b0;
      unique case (h_st_ff)
        H_IDLE: begin
          if (req_i && (!sync_i || fall_evt)) begin
            we_ff                      <= we_i;
            busy_o                     <= 1'b1;
            bus.addr                   <= addr_i;
            bus.address_qualifier_n    <= 1'b0;
            bus.byte_lane_select_n     <= be_n_i;
            bus.address_latch_strobe_n <= 1'b0;
            bus.host_d_o               <= wdata_i;
            if (sync_i) begin
              bus.sync_cycle_frame_n <= 1'b0;
              bus.transfer_direction <= we_i; // R12
              h_st_ff                <= H_CYC;
            end else begin
              h_st_ff <= H_ADDR;
            end
          end
        end
        H_ADDR: begin
          bus.address_latch_strobe_n <= 1'b1;
          bus.async_read_strobe_n    <= we_ff; // R19
          bus.async_write_strobe_n   <= ~we_ff;
          bus.host_d_oe              <= we_ff;
          cnt_ff                     <= '0;
          h_st_ff                    <= H_STROBE;
        end
        H_STROBE: begin
          if (cnt_ff != 4'(hbiu_pkg::HOST_STROBE_CYC)) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (rdy_s2_ff) begin
            rdata_o                  <= bus.data;
            bus.async_read_strobe_n  <= 1'b1;
            bus.async_write_strobe_n <= 1'b1;
            bus.host_d_oe            <= 1'b0;
            bus.address_qualifier_n  <= 1'b1;
            done_o                   <= 1'b1;
            busy_o                   <= 1'b0;
            h_st_ff                  <= H_IDLE;
          end
        end
        H_CYC: begin
          if (fall_evt) begin
            bus.sync_cycle_frame_n     <= 1'b1;
            bus.address_latch_strobe_n <= 1'b1;
            bus.host_d_oe              <= we_ff; // R10
            h_st_ff                    <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (fall_evt && !bus.sync_ready_out_n) begin
            rdata_o       <= bus.data;
            bus.host_d_oe <= 1'b0;
            if (we_ff) begin
              bus.address_qualifier_n <= 1'b1;
              done_o                  <= 1'b1;
              busy_o                  <= 1'b0;
              h_st_ff                 <= H_IDLE;
            end else begin
              bus.ready_return_in_n <= 1'b0; // R17
              h_st_ff               <= H_RTN;
            end
          end
        end
        H_RTN: begin
          if (fall_evt) begin
            bus.ready_return_in_n   <= 1'b1;
            bus.address_qualifier_n <= 1'b1;
            done_o                  <= 1'b1;
            busy_o                  <= 1'b0;
            h_st_ff                 <= H_IDLE;
          end
        end
        default: h_st_ff <= H_IDLE;
      endcase
    end
  end
endmodule

/* File: verification/hbiu_checker.sv */
// assertions on the pins between host and device
// assumes the base address keeps its reset value
`timescale 1ns/1ps
module hbiu_checker (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        host_bus_clock,
  input wire logic [15:1] addr,
  input wire logic        address_qualifier_n,
  input wire logic        local_device_hit_n,
  input wire logic        dev_ad_oe,
  input wire logic        dev_sd_oe,
  input wire logic        async_read_strobe_n,
  input wire logic        async_ready_od,
  input wire logic        sync_ready_out_n,
  input wire logic        ready_return_in_n,
  input wire logic        transfer_direction
);
  sequence s_async_ready_od_low;
    !async_ready_od[*3];
  endsequence
  property p_hit;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !address_qualifier_n && addr[15:4] == 12'h030 |-> !local_device_hit_n;
  endproperty
  property p_qual;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    address_qualifier_n |-> local_device_hit_n;
  endproperty
  property p_rd_drv;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(dev_ad_oe) |-> !async_read_strobe_n;
  endproperty
  property p_one_drv;
    @(posedge sys_clk_i) disable iff (!rst_n_i) !(dev_ad_oe && dev_sd_oe);
  endproperty
  property p_async_ready_od;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(async_ready_od) |-> s_async_ready_od_low ##[1:2] async_ready_od;
  endproperty
  property p_srdy;
    @(posedge host_bus_clock) disable iff (!rst_n_i)
    $fell(sync_ready_out_n) |=> sync_ready_out_n;
  endproperty
  property p_rtn;
    @(posedge host_bus_clock) disable iff (!rst_n_i)
    dev_sd_oe && !ready_return_in_n |-> ##[1:2] !dev_sd_oe;
  endproperty
  property p_dir;
    @(posedge host_bus_clock) disable iff (!rst_n_i)
    $rose(dev_sd_oe) |-> !transfer_direction;
  endproperty
  a_hit: assert property (p_hit) else $error("hit missing");
  a_qual: assert property (p_qual) else $error("hit while off");
  a_rd_drv: assert property (p_rd_drv) else $error("drive no read");
  a_one_drv: assert property (p_one_drv) else $error("two drivers");
  a_async_ready_od: assert property (p_async_ready_od) else $error("ready width");
  a_srdy: assert property (p_srdy) else $error("srdy width");
  a_rtn: assert property (p_rtn) else $error("read not ended");
  a_dir: assert property (p_dir) else $error("drive on write");
endmodule

/* File: verification/tb_host_bus_interface_unit.sv */
// host end and device end joined by the pin interface
// assumes eeprom data line held high, eeprom enabled until last reset
`timescale 1ns/1ps
module tb_host_bus_interface_unit;
  logic        clk = 0, rst_n = 0, req = 0, we = 0, syn = 0, rreq = 0, een = 1;
  logic [15:1] addr = '0;
  logic [1:0]  be = '0;
  logic [15:0] wd = '0, rdata;
  logic        done, irq, busy, ee_cs;
  int          fail_count = 0, check_count = 0;
  hbiu_if bus_if();
  hbiu_host hbiu_host_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .bus(bus_if),
    .req_i(req), .we_i(we), .sync_i(syn), .addr_i(addr), .be_n_i(be),
    .wdata_i(wd), .reset_req_i(rreq), .rdata_o(rdata), .done_o(done),
    .busy_o(busy), .irq_o(irq));
  hbiu_device hbiu_device_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
    .bus(bus_if), .eeprom_serial_in_i(1'b1), .eeprom_access_enable_i(een),
    .eeprom_serial_clock_o(), .eeprom_select_o(ee_cs),
    .eeprom_serial_out_o());
  hbiu_checker hbiu_checker_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
    .host_bus_clock(bus_if.host_bus_clock), .addr(bus_if.addr),
    .address_qualifier_n(bus_if.address_qualifier_n),
    .local_device_hit_n(bus_if.local_device_hit_n),
    .dev_ad_oe(bus_if.dev_ad_oe), .dev_sd_oe(bus_if.dev_sd_oe),
    .async_read_strobe_n(bus_if.async_read_strobe_n),
    .async_ready_od(bus_if.async_ready_od),
    .sync_ready_out_n(bus_if.sync_ready_out_n),
    .ready_return_in_n(bus_if.ready_return_in_n),
    .transfer_direction(bus_if.transfer_direction));
  initial begin
    forever #20 clk = ~clk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one access; entered and left just after a rising edge
  task acc(input logic s, w, input logic [15:1] a, input logic [1:0] b,
           input logic [15:0] d, e);
    int n;
    n = 0;
    req <= 1; syn <= s; we <= w; addr <= a; be <= b; wd <= d;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b1 && n < 500);
    @(posedge clk);
    req <= 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 500);
    chk("done", 16'h0001, {15'h0, done});
    if (!w) chk("rdata", e, rdata);
    @(posedge clk);
  endtask
  task irq_is(input logic e);
    repeat (4) @(posedge clk);
    chk("irq", {15'h0, e}, {15'h0, irq});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    acc(0, 0, 15'h0181, 2'h0, 16'h0, 16'h0300);
    acc(0, 1, 15'h0187, 2'h0, 16'h00ff, 16'h0);
    acc(0, 1, 15'h0187, 2'h2, 16'h1234, 16'h0);
    acc(0, 0, 15'h0187, 2'h0, 16'h0, 16'h0034);
    acc(1, 1, 15'h0187, 2'h1, 16'hab00, 16'h0);
    acc(1, 0, 15'h0187, 2'h0, 16'h0, 16'hab34);
    acc(0, 0, 15'h0200, 2'h0, 16'h0, 16'hffff);
    chk("eeprom_select", 16'h0001, {15'h0, ee_cs});
    $display("register tests done");
    repeat (4000) @(posedge clk);
    chk("eeprom_select", 16'h0000, {15'h0, ee_cs});
    acc(0, 0, 15'h0182, 2'h0, 16'h0, 16'hffff);
    acc(0, 1, 15'h0187, 2'h0, 16'h0001, 16'h0);
    irq_is(1);
    acc(0, 1, 15'h0186, 2'h0, 16'h0001, 16'h0);
    irq_is(0);
    $display("interrupt tests done");
    rreq <= 1;
    repeat (2) @(posedge clk);
    rreq <= 0;
    repeat (8) @(posedge clk);
    acc(0, 0, 15'h0187, 2'h0, 16'h0, 16'h0001);
    een <= 0;
    rreq <= 1;
    repeat (10) @(posedge clk);
    rreq <= 0;
    repeat (8) @(posedge clk);
    acc(0, 0, 15'h0187, 2'h0, 16'h0, 16'h0000);
    chk("eeprom_select", 16'h0000, {15'h0, ee_cs});
    $display("reset tests done");
    complete_run;
  end
  initial begin
    #1000000;
    fail_count++;
    complete_run;
  end
endmodule
